// file: rtl/lmfc_sync_pkg.sv
package lmfc_sync_pkg;
  // Register offsets
  localparam logic [11:0] OFS_SKIP_COUNT = 12'h036;
  localparam logic [11:0] OFS_JITTER_WIN = 12'h039;
  localparam logic [11:0] OFS_ONESHOT = 12'h03a;
  localparam logic [11:0] OFS_SYNC_EN = 12'h03b;
  localparam logic [11:0] OFS_MF_DELAY = 12'h304;
  localparam logic [11:0] OFS_BUF_DELAY = 12'h306;
  localparam logic [11:0] OFS_SUBCLASS = 12'h458;
  localparam logic [11:0] OFS_FRAME_OCTETS = 12'h454;
  localparam logic [11:0] OFS_STATUS = 12'h0f0;
  // Values and fields
  localparam logic [7:0] SYNC_EN_PLAIN = 8'hf1;
  localparam logic [7:0] SYNC_EN_SOFT = 8'hf3;
  localparam logic [7:0] ONESHOT_CLEAR = 8'h00;
  localparam logic [7:0] ONESHOT_ARM = 8'h02;
  localparam int ONESHOT_BIT = 1;
  localparam int DONE_BIT = 4;
  localparam int SUBCLASS_LSB = 5;
  localparam int JWIN_MSB = 5;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [7:0] FRAMES_PER_MF = 8'h20;
  localparam logic [7:0] PCLK_OCTETS = 8'h04;
  localparam logic [7:0] BUF_DELAY_MAX = 8'h0c;
  localparam logic [7:0] RAMP_CYCLES = 8'h10;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] F_RESET = 8'h01;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RAMP_DOWN, ST_WAIT_EDGE, ST_ROTATE, ST_RAMP_UP
  } sync_state_type;
endpackage : lmfc_sync_pkg

// file: rtl/mf_cfg_if.sv
`timescale 1ns/100ps
interface mf_cfg_if;
  logic [7:0] pclks_per_mf;
  logic [7:0] mf_delay;
  logic align;
  logic local_mf_clk;
  modport ctrl (output pclks_per_mf, output mf_delay, output align,
    input local_mf_clk);
  modport counter (input pclks_per_mf, input mf_delay, input align,
    output local_mf_clk);
endinterface : mf_cfg_if

// file: rtl/local_mf_counter.sv
`timescale 1ns/100ps
module local_mf_counter
  import lmfc_sync_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Config
  mf_cfg_if.counter cfg
);
  logic [7:0] phase_r;
  logic [7:0] phase_nxt;
  logic [7:0] tap;

  // Reference phase, wraps on the multiframe period
  always_comb
  begin
    phase_nxt = phase_r + 8'h01;
    if (cfg.align || phase_nxt >= cfg.pclks_per_mf)
      phase_nxt = RESET_ZERO;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      phase_r <= RESET_ZERO;
    else
      phase_r <= phase_nxt;
  end

  // Delayed local edge sits mf_delay cycles after reference zero
  assign tap = cfg.mf_delay;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cfg.local_mf_clk <= 1'b0;
    else
      // Never two in a row, even when an alignment lands just after a wrap
      cfg.local_mf_clk <= (phase_nxt == tap) && !cfg.local_mf_clk;
  end
endmodule : local_mf_counter

// file: rtl/lmfc_sync.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module lmfc_sync
  import lmfc_sync_pkg::*;
#(
  parameter int LINKS = 2,
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Alignment reference
  input wire logic sysref,
  // Sample stream, two channels
  input wire logic [DATA_W-1:0] ch0_in,
  input wire logic [DATA_W-1:0] ch1_in,
  input wire logic data_in_valid,
  output logic [DATA_W-1:0] ch0_out,
  output logic [DATA_W-1:0] ch1_out,
  output logic data_out_valid,
  // Link status
  output logic [LINKS-1:0] link_sync_request_out,
  output logic local_rx_multiframe_clock,
  output logic sysref_jitter_irq
);
  localparam int DEPTH = 16;

  logic [7:0] skip_r;
  logic [7:0] jwin_r;
  logic [7:0] sync_en_r;
  logic [7:0] mf_delay_r;
  logic [7:0] buf_delay_r;
  logic [7:0] subclass_r;
  logic [7:0] f_octets_r;
  logic armed_r;
  logic done_r;
  logic sysref_q_r;
  logic [7:0] edge_cnt_r;
  logic [7:0] ramp_cnt_r;
  logic [7:0] jit_cnt_r;
  logic [7:0] pclks_per_mf;
  logic sysref_rise;
  logic align_pulse;
  logic aligned_r;
  sync_state_type state_r;
  logic [DEPTH*DATA_W*2-1:0] pipe_r;
  logic [DEPTH-1:0] vpipe_r;
  mf_cfg_if cfg();

  // Write strobe decode, used for each register
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  // Clamp a buffer delay to the supported range
  function automatic logic [7:0] clamp_delay(input logic [7:0] d);
    clamp_delay = (d > BUF_DELAY_MAX) ? BUF_DELAY_MAX : d;
  endfunction : clamp_delay

  // K is fixed; cycles per multiframe = K*F/4
  assign pclks_per_mf = 8'((16'(FRAMES_PER_MF) * 16'(f_octets_r))
    / 16'(PCLK_OCTETS));

  // Configuration registers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      skip_r <= RESET_ZERO;
      jwin_r <= RESET_ZERO;
      sync_en_r <= RESET_ZERO;
      mf_delay_r <= RESET_ZERO;
      buf_delay_r <= RESET_ZERO;
      subclass_r <= RESET_ZERO;
      f_octets_r <= F_RESET;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, OFS_SKIP_COUNT))
        skip_r <= reg_wdata;
      if (hit(reg_addr, OFS_JITTER_WIN))
        jwin_r <= reg_wdata;
      if (hit(reg_addr, OFS_SYNC_EN))
        sync_en_r <= reg_wdata;
      if (hit(reg_addr, OFS_MF_DELAY))
        mf_delay_r <= reg_wdata;
      if (hit(reg_addr, OFS_BUF_DELAY))
        buf_delay_r <= reg_wdata;
      if (hit(reg_addr, OFS_SUBCLASS))
        subclass_r <= reg_wdata;
      if (hit(reg_addr, OFS_FRAME_OCTETS))
        f_octets_r <= reg_wdata + 8'h01;
    end
  end

  // One-shot arm bit; a clear write disarms, an arm write re-arms
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      armed_r <= 1'b0;
    else if (reg_wr && hit(reg_addr, OFS_ONESHOT))
      armed_r <= reg_wdata[ONESHOT_BIT];
  end

  logic sync_enabled;
  logic soft_mode;
  logic arm_write;
  logic sub1;
  logic sub_ok;
  assign sync_enabled = (sync_en_r == SYNC_EN_PLAIN) ||
    (sync_en_r == SYNC_EN_SOFT);
  assign soft_mode = (sync_en_r == SYNC_EN_SOFT);
  assign arm_write = reg_wr && hit(reg_addr, OFS_ONESHOT) &&
    (reg_wdata == ONESHOT_ARM) && sync_enabled && sub_ok;
  assign sub1 = (subclass_r[7:SUBCLASS_LSB] == SUBCLASS_1);
  assign sub_ok = sub1 || (subclass_r[7:SUBCLASS_LSB] == SUBCLASS_0);

  // SYSREF rising edge detect
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      sysref_q_r <= 1'b0;
    else
      sysref_q_r <= sysref;
  end
  assign sysref_rise = sysref && !sysref_q_r;

  // Alignment fires in subclass 1 on the edge after skipping, else at once
  assign align_pulse = (state_r == ST_WAIT_EDGE) &&
    (sub1 ? (sysref_rise && edge_cnt_r >= skip_r) : 1'b1);

  // Sync sequencer
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      edge_cnt_r <= RESET_ZERO;
      ramp_cnt_r <= RESET_ZERO;
    end
    else if (arm_write && sub_ok)
    begin
      state_r <= soft_mode ? ST_RAMP_DOWN : ST_WAIT_EDGE;
      edge_cnt_r <= RESET_ZERO;
      ramp_cnt_r <= RESET_ZERO;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          ;
        ST_RAMP_DOWN:
        begin
          ramp_cnt_r <= ramp_cnt_r + 8'h01;
          if (ramp_cnt_r == RAMP_CYCLES - 8'h01)
            state_r <= ST_WAIT_EDGE;
        end
        ST_WAIT_EDGE:
        begin
          if (!armed_r)
            state_r <= ST_IDLE;
          else if (align_pulse)
            state_r <= ST_ROTATE;
          else if (sysref_rise && sub1)
            edge_cnt_r <= edge_cnt_r + 8'h01;
        end
        ST_ROTATE:
        begin
          ramp_cnt_r <= RESET_ZERO;
          state_r <= soft_mode ? ST_RAMP_UP : ST_IDLE;
        end
        ST_RAMP_UP:
        begin
          ramp_cnt_r <= ramp_cnt_r + 8'h01;
          if (ramp_cnt_r == RAMP_CYCLES - 8'h01)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Done flag: set on rotation, cleared by a new request; set wins
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      done_r <= 1'b0;
    else if (state_r == ST_ROTATE)
      done_r <= 1'b1;
    else if (arm_write)
      done_r <= 1'b0;
  end

  // Aligned once a sync has happened; enables jitter monitoring
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      aligned_r <= 1'b0;
    else if (arm_write)
      aligned_r <= 1'b0;
    else if (state_r == ST_ROTATE)
      aligned_r <= 1'b1;
  end

  // Shared local multiframe counter, one alignment for both channels
  assign cfg.pclks_per_mf = pclks_per_mf;
  assign cfg.mf_delay = mf_delay_r;
  assign cfg.align = align_pulse;

  local_mf_counter i_local_mf_counter (
    .core_clk(core_clk),
    .reset(reset),
    .cfg(cfg)
  );

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      local_rx_multiframe_clock <= 1'b0;
    else
      local_rx_multiframe_clock <= cfg.local_mf_clk;
  end

  // Distance since last local edge, for the jitter window check
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      jit_cnt_r <= RESET_ZERO;
    else if (cfg.local_mf_clk || align_pulse)
      jit_cnt_r <= RESET_ZERO;
    else
      jit_cnt_r <= jit_cnt_r + 8'h01;
  end

  // Window in DAC clocks; sampling is at a quarter rate so drop 2 lsbs
  logic [7:0] win_pclk;
  logic [7:0] dist_early;
  assign win_pclk = {4'h0, jwin_r[JWIN_MSB:2]};
  assign dist_early = pclks_per_mf - jit_cnt_r;

  // Sticky jitter flag, cleared by reading status; set wins
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      sysref_jitter_irq <= 1'b0;
    else if (aligned_r && sub1 && sysref_rise && state_r == ST_IDLE &&
      jit_cnt_r > win_pclk && dist_early > win_pclk)
      sysref_jitter_irq <= 1'b1;
    else if (reg_rd && hit(reg_addr, OFS_STATUS))
      sysref_jitter_irq <= 1'b0;
  end

  // Sync request outputs drop from the request until the rotation; they are back up during the ramp-up
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      link_sync_request_out <= '0;
    else if (arm_write || (state_r != ST_IDLE && state_r != ST_ROTATE
      && state_r != ST_RAMP_UP))
      link_sync_request_out <= '0;
    else if (done_r || state_r == ST_ROTATE)
      link_sync_request_out <= '1;
  end

  // Receive buffer delay line; taps chosen by the clamped setting
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pipe_r <= '0;
      vpipe_r <= '0;
    end
    else
    begin
      pipe_r <= {pipe_r[(DEPTH-1)*DATA_W*2-1:0], ch1_in, ch0_in};
      vpipe_r <= {vpipe_r[DEPTH-2:0], data_in_valid};
    end
  end

  // Tap 0 is the same-cycle register, so delay d reads pipe entry d
  logic [7:0] buf_delay_clamped;
  logic [3:0] tap_sel;
  logic ramp_mute;
  assign buf_delay_clamped = clamp_delay(buf_delay_r);
  assign tap_sel = buf_delay_clamped[3:0];
  assign ramp_mute = soft_mode && state_r != ST_IDLE;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ch0_out <= '0;
      ch1_out <= '0;
      data_out_valid <= 1'b0;
    end
    else
    begin
      ch0_out <= ramp_mute ? '0 :
        pipe_r[tap_sel*DATA_W*2 +: DATA_W];
      ch1_out <= ramp_mute ? '0 :
        pipe_r[tap_sel*DATA_W*2 + DATA_W +: DATA_W];
      data_out_valid <= vpipe_r[tap_sel] && done_r;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= RESET_ZERO;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_SKIP_COUNT: reg_rdata <= skip_r;
        OFS_JITTER_WIN: reg_rdata <= jwin_r;
        OFS_ONESHOT: reg_rdata <= {3'h0, done_r, 2'h0, armed_r, 1'b0};
        OFS_SYNC_EN: reg_rdata <= sync_en_r;
        OFS_MF_DELAY: reg_rdata <= mf_delay_r;
        OFS_BUF_DELAY: reg_rdata <= buf_delay_r;
        OFS_SUBCLASS: reg_rdata <= subclass_r;
        OFS_FRAME_OCTETS: reg_rdata <= f_octets_r - 8'h01;
        OFS_STATUS: reg_rdata <= {7'h00, sysref_jitter_irq};
        default: reg_rdata <= RESET_ZERO;
      endcase
    end
    else
      reg_rdata <= RESET_ZERO;
  end
endmodule : lmfc_sync

// file: tb/sysref_src.sv
`timescale 1ns/100ps
module sysref_src
(
  // Clock
  input wire logic core_clk,
  // Reference out
  output logic sysref
);
  initial sysref = 1'b0;

  // n rising edges, gap cycles apart; low outside bursts
  task fire(input int n, input int gap);
    repeat (n)
    begin
      @(posedge core_clk);
      sysref <= 1'b1;
      repeat (2) @(posedge core_clk);
      sysref <= 1'b0;
      repeat (gap - 3) @(posedge core_clk);
    end
  endtask : fire
endmodule : sysref_src

// file: tb/lmfc_sync_chk.sv
`timescale 1ns/100ps
module lmfc_sync_chk
  import lmfc_sync_pkg::*;
#(
  parameter int LINKS = 2,
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic sysref,
  input wire logic [DATA_W-1:0] ch0_out,
  input wire logic [LINKS-1:0] link_sync_request_out,
  input wire logic local_rx_multiframe_clock,
  input wire logic sysref_jitter_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic en_r, soft_r, sc1_r, ok_r;
  wire arm = reg_wr && reg_addr == OFS_ONESHOT && reg_wdata == ONESHOT_ARM;
  wire [LINKS-1:0] lk = link_sync_request_out;

  // Shadow of host setup, so refused arms can be told apart
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      en_r <= 1'b0;
      soft_r <= 1'b0;
      sc1_r <= 1'b0;
      ok_r <= 1'b1;
    end
    else if (reg_wr && reg_addr == OFS_SYNC_EN)
    begin
      en_r <= reg_wdata == SYNC_EN_PLAIN || reg_wdata == SYNC_EN_SOFT;
      soft_r <= reg_wdata == SYNC_EN_SOFT;
    end
    else if (reg_wr && reg_addr == OFS_SUBCLASS)
    begin
      sc1_r <= reg_wdata[7:5] == SUBCLASS_1;
      ok_r <= reg_wdata[7:5] <= SUBCLASS_1;
    end
  end

  sequence s_go; arm && en_r && ok_r; endsequence
  sequence s_sc0; s_go ##0 !soft_r && !sc1_r; endsequence
  sequence s_sc1; s_go ##0 !soft_r && sc1_r; endsequence
  sequence s_soft; s_go ##0 soft_r; endsequence

  property p_rdz; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("rdata not idle");
  property p_drop; s_go |=> lk == '0; endproperty
  a_drop: assert property (p_drop) else $error("links not dropped");
  property p_sc0; s_sc0 |=> lk == '0 ##2 lk == '1; endproperty
  a_sc0: assert property (p_sc0) else $error("sc0 restore late");
  property p_sc1; s_sc1 ##1 !sysref [*3] |=> lk == '0; endproperty
  a_sc1: assert property (p_sc1) else $error("sync without edge");
  property p_soft;
    s_soft |=> lk == '0 ##1 (lk == '0 && ch0_out == '0) [*8];
  endproperty
  a_soft: assert property (p_soft) else $error("ramp too short");
  property p_refuse; arm && !(en_r && ok_r) |=> $stable(lk); endproperty
  a_refuse: assert property (p_refuse) else $error("bad arm taken");
  property p_mf;
    local_rx_multiframe_clock |=> !local_rx_multiframe_clock;
  endproperty
  a_mf: assert property (p_mf) else $error("mf pulse too long");
  property p_jit;
    sysref_jitter_irq && !(reg_rd && reg_addr == OFS_STATUS)
      |=> sysref_jitter_irq;
  endproperty
  a_jit: assert property (p_jit) else $error("jitter flag lost");
endmodule : lmfc_sync_chk

bind lmfc_sync lmfc_sync_chk #(.LINKS(LINKS), .DATA_W(DATA_W))
  i_lmfc_sync_chk (
  .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sysref, .ch0_out, .link_sync_request_out, .local_rx_multiframe_clock,
  .sysref_jitter_irq);

// file: tb/lmfc_sync_test.sv
`timescale 1ns/100ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t %h %h", $time, (a), (b)); end end
module lmfc_sync_test
  import lmfc_sync_pkg::*;
;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, d;
  logic sysref, data_in_valid = 1'b0, data_out_valid, irq, mfc;
  logic [15:0] ch0_in = '0, ch1_in = '0, ch0_out, ch1_out;
  logic [1:0] lk;
  int failures = 0, n_tests = 0, cnt = 0, l0, l1, t0, t1;

  lmfc_sync i_lmfc_sync (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sysref(sysref),
    .ch0_in(ch0_in), .ch1_in(ch1_in), .data_in_valid(data_in_valid),
    .ch0_out(ch0_out), .ch1_out(ch1_out),
    .data_out_valid(data_out_valid), .link_sync_request_out(lk),
    .local_rx_multiframe_clock(mfc), .sysref_jitter_irq(irq));
  sysref_src i_sysref_src (.core_clk(core_clk), .sysref(sysref));

  always #5 core_clk = ~core_clk;

  task summarize();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Hang guard; whole run needs a few hundred cycles
  always @(posedge core_clk)
  begin
    cnt++;
    if (cnt == 20000)
    begin
      failures++;
      summarize();
    end
  end

  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task arm();
    wr(OFS_ONESHOT, ONESHOT_CLEAR);
    wr(OFS_ONESHOT, ONESHOT_ARM);
  endtask : arm

  // Bounded wait for the links to come back up
  task wlink();
    for (int i = 0; i < 200 && lk !== 2'h3; i++)
      @(posedge core_clk);
    #1;
  endtask : wlink

  task t_regs();
    logic [11:0] a [4] = '{12'h036, 12'h039, 12'h304, 12'h306};
    foreach (a[i])
    begin
      rd(a[i]);
      `CK(d, 8'h00)
      wr(a[i], 8'h05 + 8'(i));
      rd(a[i]);
      `CK(d, 8'h05 + 8'(i))
      wr(a[i], 8'h00);
    end
    wr(12'h100, 8'hff);
    rd(12'h100);
    `CK(d, 8'h00)
  endtask : t_regs

  task t_sc0();
    arm();
    repeat (4) @(posedge core_clk);
    rd(OFS_ONESHOT);
    `CK(d[DONE_BIT], 1'b0)
    wr(OFS_SYNC_EN, SYNC_EN_PLAIN);
    arm();
    wlink();
    `CK(lk, 2'h3)
    rd(OFS_ONESHOT);
    `CK(d[DONE_BIT], 1'b1)
    repeat (20) @(posedge core_clk);
    rd(OFS_ONESHOT);
    `CK(d[DONE_BIT], 1'b1)
    wr(OFS_SUBCLASS, 8'h40);
    arm();
    rd(OFS_ONESHOT);
    `CK(lk, 2'h3)
    `CK(d[DONE_BIT], 1'b1)
    wr(OFS_SUBCLASS, 8'h00);
  endtask : t_sc0

  task t_sc1();
    wr(OFS_SUBCLASS, 8'h20);
    wr(OFS_JITTER_WIN, 8'h00);
    wr(OFS_SKIP_COUNT, 8'h02);
    arm();
    repeat (4) @(posedge core_clk);
    i_sysref_src.fire(2, 8);
    rd(OFS_ONESHOT);
    `CK(lk, 2'h0)
    `CK(d[DONE_BIT], 1'b0)
    i_sysref_src.fire(1, 8);
    wlink();
    `CK(lk, 2'h3)
    rd(OFS_ONESHOT);
    `CK(d[DONE_BIT], 1'b1)
    `CK(irq, 1'b0)
    i_sysref_src.fire(2, 5);
    `CK(irq, 1'b1)
    rd(OFS_STATUS);
    `CK(d[0], 1'b1)
    `CK(irq, 1'b0)
    wr(OFS_SUBCLASS, 8'h00);
  endtask : t_sc1

  task t_soft();
    wr(OFS_SYNC_EN, SYNC_EN_SOFT);
    ch0_in <= 16'h1234;
    data_in_valid <= 1'b1;
    arm();
    @(posedge core_clk);
    #1;
    `CK(ch0_out, 16'h0000)
    wlink();
    repeat (20) @(posedge core_clk);
    #1;
    `CK(ch0_out, 16'h1234)
    data_in_valid <= 1'b0;
    wr(OFS_SYNC_EN, SYNC_EN_PLAIN);
  endtask : t_soft

  // Cycles from one input sample to its output, for delay v
  task lat(input logic [7:0] v, output int n);
    wr(OFS_BUF_DELAY, v);
    repeat (20) @(posedge core_clk);
    ch0_in <= 16'habcd;
    ch1_in <= 16'h5678;
    data_in_valid <= 1'b1;
    @(posedge core_clk);
    data_in_valid <= 1'b0;
    ch0_in <= 16'h0000;
    ch1_in <= 16'h0000;
    for (n = 0; n < 40; n++)
    begin
      @(posedge core_clk);
      #1;
      if (data_out_valid === 1'b1)
        break;
    end
    `CK(ch0_out, 16'habcd)
    `CK(ch1_out, 16'h5678)
  endtask : lat

  task t_buf();
    lat(8'h00, l0);
    lat(8'h05, l1);
    `CK(l1 - l0, 5)
    lat(8'h0c, l1);
    `CK(l1 - l0, 12)
    lat(8'h0f, l1);
    `CK(l1 - l0, 12)
  endtask : t_buf

  // Cycle count at the next multiframe pulse
  task at(output int t);
    for (int i = 0; i < 40 && mfc !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    t = cnt;
    @(posedge core_clk);
    #1;
  endtask : at

  task t_mf();
    at(t0);
    at(t1);
    `CK(t1 - t0, 8)
    wr(OFS_FRAME_OCTETS, 8'h01);
    at(t0);
    at(t0);
    at(t1);
    `CK(t1 - t0, 16)
    wr(OFS_FRAME_OCTETS, 8'h00);
    at(t0);
    at(t0);
    wr(OFS_MF_DELAY, 8'h03);
    at(t1);
    `CK((t1 - t0) % 8, 3)
  endtask : t_mf

  initial
  begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_sc0();
    t_sc1();
    t_soft();
    t_buf();
    t_mf();
    summarize();
  end
endmodule : lmfc_sync_test
